//--- rtl/rsc_pkg.sv
package rsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 100;                      // 10 MHz mclk
  localparam int MS_NS = 1000000;                   // One millisecond
  localparam int CYC_PER_MS = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] OFF_MIN_MS = 10'h001;      // Floor on off-step waits
  localparam logic [9:0] LINGER_MS = 10'h0C8;       // 200 ms before shutdown
  localparam logic [9:0] SAMPLE_MS = 10'h3E8;       // 1 s compensation period
  localparam logic [9:0] TFLT_UNIT_MS = 10'h00A;    // Current-limit time step

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] TEMP_OFS = 8'h01;
  localparam logic [7:0] CFG_OFS = 8'h02;
  localparam logic [7:0] ROOM_TEMP_COMMON_SETTING_OFS = 8'h03;
  localparam logic [7:0] DLY_OFS = 8'h04;
  localparam logic [7:0] VCOML_OFS = 8'h05;
  localparam logic [7:0] VCOMH1_OFS = 8'h06;
  localparam logic [7:0] VCOMH2_OFS = 8'h07;
  localparam logic [7:0] VTL_OFS = 8'h08;
  localparam logic [7:0] VTH1_OFS = 8'h09;
  localparam logic [7:0] VTH2_OFS = 8'h0A;
  localparam logic [7:0] VMIN_OFS = 8'h0B;
  localparam logic [7:0] VMAX_OFS = 8'h0C;
  localparam logic [7:0] FLT2_OFS = 8'h0D;
  localparam logic [7:0] BURN_OFS = 8'h78;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and field positions
  localparam logic [7:0] CFG_RST = 8'h00;           // External sensor
  localparam logic [7:0] ROOM_TEMP_COMMON_SETTING_RST = 8'hB6;
  localparam logic [7:0] DLY_RST = 8'h01;
  localparam logic [7:0] VCOML_RST = 8'h40;         // Sequence code 3'h2
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] VMAX_RST = 8'hFF;
  localparam int CFG_INTS_B = 0;                    // Internal sensor select
  localparam int CFG_TFLT_B = 1;                    // Two-bit fault time
  localparam int DLY_LSB_B = 0;                     // Common setting LSB
  localparam int DLY_TC_B = 1;                      // Compensation enable
  localparam int SEQ_B = 5;                         // Three-bit sequence code
  localparam int F2_VCOM_B = 0;                     // Common fault flag

  ////////////////////////////////////////////////////////////////////////////
  // Rails and sequence table, one 5-bit group per step, step 0 lowest
  localparam logic [4:0] R_AV = 5'h01;
  localparam logic [4:0] R_NAV = 5'h02;
  localparam logic [4:0] R_VOFF = 5'h04;
  localparam logic [4:0] R_VON = 5'h08;
  localparam logic [4:0] R_COM = 5'h10;
  localparam int RAIL_COM_B = 4;
  localparam logic [19:0] SEQ_TBL [8] = '{
    {R_VON | R_COM, R_VOFF, R_NAV, R_AV},
    {R_VOFF | R_COM, R_VON, R_NAV, R_AV},
    {R_VON | R_COM, R_VOFF, R_AV, R_NAV},
    {R_VOFF | R_COM, R_VON, R_AV, R_NAV},
    {R_VON | R_COM, R_AV, R_VOFF, R_NAV},
    {R_AV | R_COM, R_NAV, R_VON, R_VOFF},
    {5'h00, R_VON | R_COM, R_VOFF, R_AV | R_NAV},
    {5'h00, R_VOFF | R_COM, R_VON, R_AV | R_NAV}
  };

  typedef enum logic [2:0] {
    ST_SHDN = 3'h0,
    ST_UP = 3'h1,
    ST_ON = 3'h2,
    ST_DOWN = 3'h3,
    ST_LINGER = 3'h4,
    ST_FLT = 3'h5
  } rsc_state_t;

  // Rails enabled once the first cnt steps are taken
  function automatic logic [4:0] rsc_rail_mask(input logic [2:0] seq,
                                               input logic [2:0] cnt);
    logic [19:0] row;
    logic [4:0] m;
    row = SEQ_TBL[seq];
    m = 5'h00;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < cnt) begin
        m = m | row[5*i +: 5];
      end
    end
    return m;
  endfunction

endpackage

//--- rtl/rsc_sync3.sv
module rsc_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins in, filtered levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;  // Metastable stage, read by s2 only
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // One chain per bit; output moves only when stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (rst) begin
        s1_r[i] <= 1'h0;
        s2_r[i] <= 1'h0;
        s3_r[i] <= 1'h0;
        q[i] <= 1'h0;
      end else begin
        s1_r[i] <= d[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

//--- rtl/rsc_ms_timer.sv
module rsc_ms_timer #(
  parameter int CYC_PER_MS = rsc_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Load restarts the wait; done pulses once at expiry
  input wire logic load,
  input wire logic [9:0] load_ms,
  output logic done
);

  localparam int CW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;

  logic [CW-1:0] cyc_r;  // Cycles within the current ms
  logic [9:0] ms_r;      // Whole ms still to wait
  logic armed_r;         // Wait in progress

  ////////////////////////////////////////////////////////////////////////////
  // Countdown; a zero load expires on the next edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      cyc_r <= '0;
      ms_r <= 10'h000;
      armed_r <= 1'h0;
      done <= 1'h0;
    end else begin
      done <= 1'h0;
      if (load) begin
        cyc_r <= '0;
        ms_r <= load_ms;
        armed_r <= 1'h1;
      end else if (armed_r) begin
        if (ms_r == 10'h000) begin
          done <= 1'h1;
          armed_r <= 1'h0;
        end else if (cyc_r == CW'(CYC_PER_MS - 1)) begin
          cyc_r <= '0;
          ms_r <= ms_r - 10'h001;
        end else begin
          cyc_r <= cyc_r + CW'(1);
        end
      end
    end
  end

endmodule

//--- rtl/rsc_rail_seq.sv
// Behaviour
// - Options 7, 8: sources, gate, gate plus common
// - Step waits come from three delay fields
// - Power-off ignores outputs, just steps with delays
// - Zero delay still spaces power-off by 1 ms
// - Core regulator off 200 ms after power-down
// - Burn command stores the selected sequence
// - Common code is room setting plus LSB
// - Deviation over 0.25 V sets common fault
// - Deviation alone leaves the buffer running
// - Long current limit: all off, fault set (core regulator stays on until 200 ms after the enable pin drops)
// - Code steps 6.83 mV from -2.49 V
// - Out-of-range write refused with NACK, no comp
// - Sensor select bit, external after reset
// - Eight-bit ADC digitises reference pin voltage
// - Temperature register shows reading under comp
// - Comp enabled: sample and update once per second
// - Start from room setting until first sample
// - Three-bit field in low register picks sequence
// - Room code minus low, plus high offsets
module rsc_rail_seq #(
  parameter int CYC_PER_MS = rsc_pkg::CYC_PER_MS  // Shorten in simulation
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port behind the serial slave
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_nack,
  // Pins
  input wire logic en_pin,
  input wire logic vcom_dev_pin,
  input wire logic vcom_ilim_pin,
  // Temperature converter
  output logic adc_start,
  output logic adc_sel_int,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  // Power outputs
  output logic [4:0] rail_en,
  output logic core_reg_en,
  output logic [8:0] vcom_code,
  // Non-volatile store request
  output logic nv_burn,
  output logic [2:0] nv_seq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] cfg_r, room_r, dly_r, vl_r, vh1_r, vh2_r;  // Software registers
  logic [7:0] vtl_r, vth1_r, vth2_r, vmin_r, vmax_r;
  logic flt_r;                      // Sticky common fault
  logic [7:0] adc_r;                // Last conversion
  logic comp_valid_r;               // A sample exists since enable
  logic upd_r;                      // Fresh sample, apply it
  logic [8:0] vcom_code_r;
  logic [4:0] rail_en_r;
  logic core_reg_en_r;
  logic adc_start_r;
  logic nv_burn_r;
  logic [2:0] nv_seq_r;
  logic [7:0] reg_rdata_r;
  rsc_pkg::rsc_state_t st_r;
  logic [2:0] on_cnt_r;             // Steps currently enabled
  logic [2:0] seq_act_r;            // Sequence latched at power-up
  logic seq_load_r;                 // Step timer load
  logic [9:0] seq_ms_r;             // Step timer value
  logic seq_done, smp_done, ilim_done;
  logic en_s, dev_s, ilim_s;        // Filtered pins
  logic tc;                         // Compensation enabled
  logic [8:0] base;                 // Room-temperature code
  logic [8:0] comp_code;
  logic [2:0] nsteps;
  logic [2:0] cnt_up, cnt_dn;
  logic [1:0] off_idx;
  logic out_of_range;
  logic ilim_trip;
  logic running;
  logic [9:0] tflt_ms;

  ////////////////////////////////////////////////////////////////////////////
  // Pin filtering and timers
  rsc_sync3 #(.W(3)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({en_pin, vcom_dev_pin, vcom_ilim_pin}),
    .q({en_s, dev_s, ilim_s})
  );

  rsc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_seq_tmr (
    .mclk(mclk),
    .rst(rst),
    .load(seq_load_r),
    .load_ms(seq_ms_r),
    .done(seq_done)
  );

  // Free-runs while compensation is on; held reloaded otherwise
  rsc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_smp_tmr (
    .mclk(mclk),
    .rst(rst),
    .load(!tc || smp_done),
    .load_ms(rsc_pkg::SAMPLE_MS),
    .done(smp_done)
  );

  // Reloaded whenever not in limit, so it expires only on a continuous run
  rsc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_ilim_tmr (
    .mclk(mclk),
    .rst(rst),
    .load(!ilim_s || !running),
    .load_ms(tflt_ms),
    .done(ilim_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [9:0] step_ms(input logic [1:0] idx, input logic [7:0] dly);
    logic [7:0] sh;
    sh = dly >> {idx, 1'h0};
    return {8'h00, sh[1:0]};
  endfunction

  assign tc = dly_r[rsc_pkg::DLY_TC_B];
  assign base = {room_r, dly_r[rsc_pkg::DLY_LSB_B]};
  assign nsteps = (seq_act_r[2:1] == 2'h3) ? 3'h3 : 3'h4;
  assign cnt_up = on_cnt_r + 3'h1;
  assign cnt_dn = on_cnt_r - 3'h1;
  // Off waits run t3, t2, t1 (t3, t2 for three-step sequences) counted from the first step turned off
  assign off_idx = 2'(3'h4 - nsteps + cnt_dn);
  assign running = (st_r == rsc_pkg::ST_UP) || (st_r == rsc_pkg::ST_ON)
                   || (st_r == rsc_pkg::ST_DOWN);
  assign ilim_trip = ilim_done && running;
  assign tflt_ms = 10'(({8'h00, cfg_r[rsc_pkg::CFG_TFLT_B +: 2]} + 10'h001)
                       * rsc_pkg::TFLT_UNIT_MS);
  // Guard only applies with compensation off
  assign out_of_range = !tc && ((reg_wdata < vmin_r) || (reg_wdata > vmax_r));

  ////////////////////////////////////////////////////////////////////////////
  // Compensation: room code moved by band offsets, clamped to 9 bits
  always_comb begin
    logic [9:0] up_sum;
    up_sum = {1'h0, base} + {5'h00, vh1_r[4:0]};
    if (adc_r >= vth2_r) begin
      up_sum = up_sum + {5'h00, vh2_r[4:0]};
    end
    if (adc_r <= vtl_r) begin
      comp_code = (base < {4'h0, vl_r[4:0]}) ? 9'h000 : base - {4'h0, vl_r[4:0]};
    end else if (adc_r >= vth1_r) begin
      comp_code = up_sum[9] ? 9'h1FF : up_sum[8:0];
    end else begin
      comp_code = base;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; the sequence field must not move mid-sequence
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= rsc_pkg::CFG_RST;
      room_r <= rsc_pkg::ROOM_TEMP_COMMON_SETTING_RST;
      dly_r <= rsc_pkg::DLY_RST;
      vl_r <= rsc_pkg::VCOML_RST;
      vh1_r <= rsc_pkg::ZERO_RST;
      vh2_r <= rsc_pkg::ZERO_RST;
      vtl_r <= rsc_pkg::ZERO_RST;
      vth1_r <= rsc_pkg::VMAX_RST;
      vth2_r <= rsc_pkg::VMAX_RST;
      vmin_r <= rsc_pkg::ZERO_RST;
      vmax_r <= rsc_pkg::VMAX_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        rsc_pkg::CFG_OFS: cfg_r <= reg_wdata;
        rsc_pkg::ROOM_TEMP_COMMON_SETTING_OFS: begin
          // Refused value leaves the setting as it was
          if (!out_of_range) begin
            room_r <= reg_wdata;
          end
        end
        rsc_pkg::DLY_OFS: dly_r <= reg_wdata;
        rsc_pkg::VCOML_OFS: vl_r <= reg_wdata;
        rsc_pkg::VCOMH1_OFS: vh1_r <= reg_wdata;
        rsc_pkg::VCOMH2_OFS: vh2_r <= reg_wdata;
        rsc_pkg::VTL_OFS: vtl_r <= reg_wdata;
        rsc_pkg::VTH1_OFS: vth1_r <= reg_wdata;
        rsc_pkg::VTH2_OFS: vth2_r <= reg_wdata;
        rsc_pkg::VMIN_OFS: vmin_r <= reg_wdata;
        rsc_pkg::VMAX_OFS: vmax_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // NACK answers in the same cycle as the refused write
  assign reg_nack = reg_wr && (reg_addr == rsc_pkg::ROOM_TEMP_COMMON_SETTING_OFS) && out_of_range;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        rsc_pkg::TEMP_OFS: reg_rdata_r <= tc ? adc_r : 8'h00;
        rsc_pkg::CFG_OFS: reg_rdata_r <= cfg_r;
        rsc_pkg::ROOM_TEMP_COMMON_SETTING_OFS: reg_rdata_r <= room_r;
        rsc_pkg::DLY_OFS: reg_rdata_r <= dly_r;
        rsc_pkg::VCOML_OFS: reg_rdata_r <= vl_r;
        rsc_pkg::VCOMH1_OFS: reg_rdata_r <= vh1_r;
        rsc_pkg::VCOMH2_OFS: reg_rdata_r <= vh2_r;
        rsc_pkg::VTL_OFS: reg_rdata_r <= vtl_r;
        rsc_pkg::VTH1_OFS: reg_rdata_r <= vth1_r;
        rsc_pkg::VTH2_OFS: reg_rdata_r <= vth2_r;
        rsc_pkg::VMIN_OFS: reg_rdata_r <= vmin_r;
        rsc_pkg::VMAX_OFS: reg_rdata_r <= vmax_r;
        rsc_pkg::FLT2_OFS: reg_rdata_r <= {7'h00, flt_r};
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common fault flag: write one to clear, a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      flt_r <= 1'h0;
    end else if (dev_s || ilim_trip) begin
      flt_r <= 1'h1;
    end else if (reg_wr && (reg_addr == rsc_pkg::FLT2_OFS)
                 && reg_wdata[rsc_pkg::F2_VCOM_B]) begin
      flt_r <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burn command captures the selected sequence for the store
  always_ff @(posedge mclk) begin
    if (rst) begin
      nv_burn_r <= 1'h0;
      nv_seq_r <= 3'h0;
    end else begin
      nv_burn_r <= reg_wr && (reg_addr == rsc_pkg::BURN_OFS);
      if (reg_wr && (reg_addr == rsc_pkg::BURN_OFS)) begin
        nv_seq_r <= vl_r[rsc_pkg::SEQ_B +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= rsc_pkg::ST_SHDN;
      on_cnt_r <= 3'h0;
      seq_act_r <= 3'h0;
      seq_load_r <= 1'h0;
      seq_ms_r <= 10'h000;
    end else begin
      seq_load_r <= 1'h0;
      if (ilim_trip) begin
        // Buffer stuck in limit: drop all rails at once, core regulator stays on
        st_r <= rsc_pkg::ST_FLT;
        on_cnt_r <= 3'h0;
      end else begin
        unique case (st_r)
          rsc_pkg::ST_SHDN: begin
            // Only the enable pin wakes the device
            if (en_s) begin
              st_r <= rsc_pkg::ST_UP;
              on_cnt_r <= 3'h0;
              seq_act_r <= vl_r[rsc_pkg::SEQ_B +: 3];
              seq_load_r <= 1'h1;
              seq_ms_r <= 10'h000;
            end
          end
          rsc_pkg::ST_UP: begin
            if (!en_s) begin
              st_r <= rsc_pkg::ST_DOWN;
              seq_load_r <= 1'h1;
              seq_ms_r <= 10'h000;
            end else if (seq_done) begin
              on_cnt_r <= cnt_up;
              if (cnt_up == nsteps) begin
                st_r <= rsc_pkg::ST_ON;
              end else begin
                seq_load_r <= 1'h1;
                seq_ms_r <= step_ms(cnt_up[1:0], dly_r);
              end
            end
          end
          rsc_pkg::ST_ON: begin
            // Deviation fault alone keeps everything running
            if (!en_s) begin
              st_r <= rsc_pkg::ST_DOWN;
              seq_load_r <= 1'h1;
              seq_ms_r <= 10'h000;
            end
          end
          rsc_pkg::ST_DOWN: begin
            // No output checks here, steps follow the timer only
            if (seq_done) begin
              seq_load_r <= 1'h1;
              if (on_cnt_r == 3'h0) begin
                st_r <= rsc_pkg::ST_LINGER;
                seq_ms_r <= rsc_pkg::LINGER_MS;
              end else begin
                on_cnt_r <= cnt_dn;
                if (cnt_dn == 3'h0) begin
                  st_r <= rsc_pkg::ST_LINGER;
                  seq_ms_r <= rsc_pkg::LINGER_MS;
                end else if (step_ms(off_idx, dly_r) == 10'h000) begin
                  seq_ms_r <= rsc_pkg::OFF_MIN_MS;
                end else begin
                  seq_ms_r <= step_ms(off_idx, dly_r);
                end
              end
            end
          end
          rsc_pkg::ST_LINGER: begin
            if (seq_done) begin
              st_r <= rsc_pkg::ST_SHDN;
            end
          end
          rsc_pkg::ST_FLT: begin
            // Latched off until the enable pin is released
            if (!en_s) begin
              st_r <= rsc_pkg::ST_LINGER;
              seq_load_r <= 1'h1;
              seq_ms_r <= rsc_pkg::LINGER_MS;
            end
          end
          default: st_r <= rsc_pkg::ST_SHDN;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail and core regulator outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      rail_en_r <= 5'h00;
      core_reg_en_r <= 1'h0;
    end else begin
      rail_en_r <= rsc_pkg::rsc_rail_mask(seq_act_r, on_cnt_r);
      core_reg_en_r <= (st_r != rsc_pkg::ST_SHDN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature sampling, once per period while enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      adc_start_r <= 1'h0;
      adc_r <= 8'h00;
      comp_valid_r <= 1'h0;
      upd_r <= 1'h0;
    end else begin
      adc_start_r <= tc && smp_done;
      upd_r <= tc && adc_valid;
      if (adc_valid) begin
        adc_r <= adc_data;
      end
      if (!tc) begin
        comp_valid_r <= 1'h0;
      end else if (adc_valid) begin
        comp_valid_r <= 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common code: room value until a sample exists, then per-sample updates
  always_ff @(posedge mclk) begin
    if (rst) begin
      vcom_code_r <= 9'h000;
    end else if (!comp_valid_r) begin
      vcom_code_r <= base;
    end else if (upd_r) begin
      vcom_code_r <= comp_code;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign adc_start = adc_start_r;
  assign adc_sel_int = cfg_r[rsc_pkg::CFG_INTS_B];
  assign rail_en = rail_en_r;
  assign core_reg_en = core_reg_en_r;
  assign vcom_code = vcom_code_r;
  assign nv_burn = nv_burn_r;
  assign nv_seq = nv_seq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  AST_SEQ7_FIRST: assert property (
    (on_cnt_r == 3'h1 && seq_act_r == 3'h6) |=> rail_en_r == 5'h03)
    else $error("option 7 first step not both source rails");
  AST_OFF_MIN: assert property (
    (st_r == rsc_pkg::ST_DOWN && $past(st_r) == rsc_pkg::ST_DOWN && seq_load_r)
    |-> seq_ms_r != 10'h000)
    else $error("power-off wait shorter than 1 ms");
  AST_LINGER_SHDN: assert property (
    (st_r == rsc_pkg::ST_LINGER && seq_done && !ilim_trip)
    |=> st_r == rsc_pkg::ST_SHDN ##1 !core_reg_en_r)
    else $error("core regulator not off after linger");
  AST_BURN: assert property (
    (reg_wr && reg_addr == rsc_pkg::BURN_OFS)
    |=> nv_burn_r && nv_seq_r == $past(vl_r[rsc_pkg::SEQ_B +: 3]))
    else $error("burn did not carry sequence");
  AST_DEV_FLAG: assert property (
    dev_s |=> flt_r)
    else $error("deviation not flagged");
  AST_DEV_KEEP: assert property (
    (st_r == rsc_pkg::ST_ON && en_s && !ilim_trip) |=> rail_en_r[rsc_pkg::RAIL_COM_B])
    else $error("buffer dropped without current limit");
  AST_ILIM_OFF: assert property (
    ilim_trip |=> ##1 (rail_en_r == 5'h00 && flt_r))
    else $error("current limit did not shut outputs");
  AST_GUARD_NACK: assert property (
    (reg_wr && reg_addr == rsc_pkg::ROOM_TEMP_COMMON_SETTING_OFS && out_of_range)
    |-> reg_nack ##1 room_r == $past(room_r))
    else $error("out-of-range write not refused");
  AST_TEMP_READ: assert property (
    (reg_rd && reg_addr == rsc_pkg::TEMP_OFS && tc) |=> reg_rdata == $past(adc_r))
    else $error("temperature register not last reading");
  AST_START_ROOM: assert property (
    !comp_valid_r |=> vcom_code_r == $past(base))
    else $error("common code not room value before sample");

endmodule

//--- bench/rsc_adc_model.sv
// Converter stand-in: answers each start a few cycles later
module rsc_adc_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request side
  input wire logic adc_start,
  input wire logic adc_sel_int,
  // Result side
  output logic adc_valid,
  output logic [7:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dly_r; // Conversion delay countdown
  // Eight-bit result, source picked by the select line
  always_ff @(posedge mclk) begin
    adc_valid <= 1'b0;
    adc_data <= ~adc_data; // Stale data never looks valid
    if (rst) begin
      dly_r <= 3'h0;
      adc_data <= 8'h00;
    end else if (adc_start) begin
      dly_r <= 3'h3;
    end else if (dly_r != 3'h0) begin
      dly_r <= dly_r - 3'h1;
      if (dly_r == 3'h1) begin
        adc_valid <= 1'b1;
        adc_data <= adc_sel_int ? 8'h3C : 8'h5A;
      end
    end
  end
endmodule

//--- bench/rail_sequence_common_volt_tb_top.sv
module rail_sequence_common_volt_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, en_pin = 0, dev = 0, adc_valid, nack;
  logic adc_start, sel, core_en, burn, ilim = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, adc_data;
  logic [4:0] rail;
  logic [8:0] code;
  logic [2:0] nseq;
  int n_fail = 0, tests_run = 0, cyc = 0, t0 = 0;
  initial forever #50 mclk = ~mclk;
  // Short ms so the 200 ms linger fits the run
  rsc_rail_seq #(.CYC_PER_MS(10)) i_rsc_rail_seq (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_nack(nack),
    .en_pin(en_pin), .vcom_dev_pin(dev), .vcom_ilim_pin(ilim), .adc_start(adc_start),
    .adc_sel_int(sel), .adc_valid(adc_valid), .adc_data(adc_data), .rail_en(rail),
    .core_reg_en(core_en), .vcom_code(code), .nv_burn(burn), .nv_seq(nseq));
  rsc_adc_model i_rsc_adc_model (.mclk(mclk), .rst(rst), .adc_start(adc_start),
    .adc_sel_int(sel), .adc_valid(adc_valid), .adc_data(adc_data));
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  // One byte write, nack looked at while the strobe is up
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_nack);
    @(negedge mclk);
    reg_wr = 1;
    addr = a;
    wdata = d;
    #1 chk(9'(nack), 9'(exp_nack));
    @(negedge mclk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_rd = 1;
    addr = a;
    @(negedge mclk);
    reg_rd = 0;
    chk(9'(rdata), 9'(exp));
  endtask
  // Wait for a rail pattern, return cycles spent
  task automatic wait_rail(input logic [4:0] exp, output int n);
    n = 0;
    while (rail !== exp && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk(9'(rail), 9'(exp));
  endtask
  task automatic run_seq(input logic [2:0] sc, input logic [4:0] mid);
    int n;
    wr(8'h05, {sc, 5'h00}, 1'b0);
    en_pin = 1;
    wait_rail(5'h03, n);
    wait_rail(mid, n);
    wait_rail(5'h1F, n);
    dev = 1;
    repeat (8) @(negedge mclk);
    rd(8'h0D, 8'h01);
    chk(9'(rail), 9'h01F);
    dev = 0;
    // Let the filtered level fall first, else the set would win over the clear
    repeat (5) @(negedge mclk);
    wr(8'h0D, 8'h01, 1'b0);
    rd(8'h0D, 8'h00);
    en_pin = 0;
    wait_rail(mid, n);
    wait_rail(5'h03, n);
    chk(9'(n >= 10), 9'h001);
    wait_rail(5'h00, n);
    chk(9'(n >= 10), 9'h001);
    n = 0;
    while (core_en !== 1'b0 && n < 2200) begin
      @(negedge mclk);
      n++;
    end
    chk(9'(n >= 1990 && n <= 2010), 9'h001);
  endtask
  // Buffer held in current limit for 10 ms: all rails drop, flag set
  task automatic run_ilim();
    int n;
    en_pin = 1;
    wait_rail(5'h1F, n);
    ilim = 1;
    n = 0;
    while (rail !== 5'h00 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk(9'(n >= 100 && n <= 120), 9'h001);
    rd(8'h0D, 8'h01);
    ilim = 0;
    en_pin = 0;
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst = 0;
    repeat (2) @(negedge mclk);
    chk(code, 9'h16D);
    chk(9'(sel), 9'h000);
    rd(8'h04, 8'h01);
    rd(8'h05, 8'h40);
    rd(8'h3F, 8'h00);
    // Guard window 0x10..0x20 on the room setting
    wr(8'h0B, 8'h10, 1'b0);
    wr(8'h0C, 8'h20, 1'b0);
    wr(8'h03, 8'h21, 1'b1);
    wr(8'h03, 8'h0F, 1'b1);
    chk(code, 9'h16D);
    wr(8'h03, 8'h18, 1'b0);
    // Code register follows the room setting one edge later
    @(negedge mclk);
    chk(code, 9'h031);
    wr(8'h04, 8'h00, 1'b0);
    run_seq(3'h6, 5'h07);
    run_seq(3'h7, 5'h0B);
    run_ilim();
    wr(8'h78, 8'h00, 1'b0);
    chk({burn, 5'h00, nseq}, 9'h107);
    rd(8'h01, 8'h00);
    wr(8'h02, 8'h01, 1'b0);
    chk(9'(sel), 9'h001);
    // Low band up to 0x40 with offset 3, so the internal reading moves the code
    wr(8'h08, 8'h40, 1'b0);
    wr(8'h05, 8'hE3, 1'b0);
    wr(8'h04, 8'h02, 1'b0);
    t0 = cyc;
    chk(code, 9'h030);
    while (adc_valid !== 1'b1 && cyc < 30000) @(negedge mclk);
    chk(9'(cyc - t0 >= 9990 && cyc - t0 <= 10020), 9'h001);
    repeat (3) @(negedge mclk);
    chk(code, 9'h02D);
    rd(8'h01, 8'h3C);
    test_done();
  end
endmodule
